// *** src/lpms_sequencer.sv ***
// lpms_sequencer: measurement cycle of a proximity and ambient light sensor
// assumes settings are stable ports driven by the host register logic
// Notes on behaviour
// - prox enabled: init, pulse accumulation, fixed wait, conversion in order
// - prox init and prox wait each last a fixed 2.73 ms
// - accumulation length follows pulse count, one led pulse per count
// - prox conversion length set by the prox conversion time setting
// - prox interrupt at end of prox conversion; sleep if sleep bit set
// - wait enabled: wait state after prox, length from setting and long bit
// - long wait bit multiplies the wait duration by twelve
// - ambient enabled: ambient init then ambient conversion
// - ambient init lasts 2.73 ms
// - ambient conversion length from ambient integration time setting
// - ambient interrupt at end of ambient conversion; sleep if sleep bit set
// - each led pulse stays on 7.3 us
// - each pulse followed by 8.7 us led off before the next
// - prox time selects 1 to 256 units of 2.73 ms; 0xFF is one unit
// - prox valid set after first prox cycle, held until prox disabled
// - an interrupt stays asserted until the host clear command
`timescale 1ns/1ps
module lpms_sequencer
    import lpms_pkg::*;
#(
    parameter int UNIT_LEN = lpms_pkg::UNIT_CYCLES,
    parameter int LED_ON_LEN = lpms_pkg::LED_ON_CYCLES,
    parameter int LED_OFF_LEN = lpms_pkg::LED_OFF_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic prox_enable,
    input wire logic wait_enable,
    input wire logic ambient_enable,
    input wire logic sleep_after_interrupt,
    input wire logic long_wait_select,
    input wire logic [lpms_pkg::SETTING_W-1:0] prox_led_pulse_count,
    input wire logic [lpms_pkg::SETTING_W-1:0] prox_conversion_time,
    input wire logic [lpms_pkg::SETTING_W-1:0] wait_time_setting,
    input wire logic [lpms_pkg::SETTING_W-1:0] ambient_integration_time,
    input wire logic prox_int_cause,
    input wire logic ambient_int_cause,
    input wire logic int_clear,
    output logic led_on,
    output logic prox_int,
    output logic ambient_int,
    output logic prox_result_valid,
    output logic prox_conv_done,
    output logic ambient_conv_done,
    output lpms_pkg::lpms_state_t state
);
    import lpms_pkg::*;

    localparam int NUM_W = 13;
    localparam int LED_W = $clog2(LED_ON_LEN + LED_OFF_LEN + 1);

    lpms_state_t state_q, state_d;
    logic [NUM_W-1:0] units;
    logic tmr_start, tmr_done;
    logic [LED_W-1:0] led_cyc_q;
    logic [SETTING_W-1:0] pulses_q;
    logic prox_int_q, amb_int_q, valid_q, led_q;

    // units from a time setting: 256 minus value
    function automatic logic [NUM_W-1:0] units_of(
        input logic [SETTING_W-1:0] v);
        units_of = NUM_W'(9'h100 - {1'b0, v});
    endfunction : units_of

    wire [NUM_W-1:0] prox_units = units_of(prox_conversion_time);
    wire [NUM_W-1:0] amb_units = units_of(ambient_integration_time);
    wire [NUM_W-1:0] wait_base = units_of(wait_time_setting);
    wire [NUM_W-1:0] wait_units = long_wait_select ?
        NUM_W'(wait_base * 4'hC) : wait_base;
    wire pend_int = prox_int_q || amb_int_q;
    wire state_chg = (state_d != state_q);
    wire pulse_end = (led_cyc_q == LED_W'(LED_ON_LEN + LED_OFF_LEN - 1));
    wire accum_done = (state_q == LPMS_PROX_ACCUM) &&
        (pulses_q == '0 || (pulse_end && pulses_q == 8'h01));
    wire prox_end = (state_q == LPMS_PROX_CONV) && tmr_done;
    wire amb_end = (state_q == LPMS_AMB_CONV) && tmr_done;
    wire prox_fire = prox_end && prox_int_cause;
    wire amb_fire = amb_end && ambient_int_cause;

    // first phase of a cycle, skipping disabled ones
    wire lpms_state_t cycle_start = prox_enable ? LPMS_PROX_INIT :
        wait_enable ? LPMS_WAIT :
        ambient_enable ? LPMS_AMB_INIT : LPMS_IDLE;
    wire lpms_state_t after_prox = wait_enable ? LPMS_WAIT :
        ambient_enable ? LPMS_AMB_INIT : cycle_start;
    wire lpms_state_t after_wait = ambient_enable ? LPMS_AMB_INIT :
        cycle_start;

    assign units = (state_d == LPMS_PROX_CONV) ? prox_units :
        (state_d == LPMS_WAIT) ? wait_units :
        (state_d == LPMS_AMB_CONV) ? amb_units : NUM_W'(1);
    assign tmr_start = state_chg && state_d != LPMS_IDLE &&
        state_d != LPMS_SLEEP && state_d != LPMS_PROX_ACCUM;

    lpms_unit_timer #(
        .UNIT_LEN(UNIT_LEN),
        .NUM_W(NUM_W)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(tmr_start),
        .num_units(units),
        .done(tmr_done)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            LPMS_IDLE: state_d = cycle_start;
            LPMS_PROX_INIT: if (tmr_done) state_d = LPMS_PROX_ACCUM;
            LPMS_PROX_ACCUM: if (accum_done) state_d = LPMS_PROX_WAIT;
            LPMS_PROX_WAIT: if (tmr_done) state_d = LPMS_PROX_CONV;
            LPMS_PROX_CONV: if (tmr_done) begin
                state_d = (prox_fire && sleep_after_interrupt) ?
                    LPMS_SLEEP : after_prox;
            end
            LPMS_WAIT: if (tmr_done) state_d = after_wait;
            LPMS_AMB_INIT: if (tmr_done) state_d = LPMS_AMB_CONV;
            LPMS_AMB_CONV: if (tmr_done) begin
                state_d = (amb_fire && sleep_after_interrupt) ?
                    LPMS_SLEEP : cycle_start;
            end
            LPMS_SLEEP: if (!pend_int) state_d = cycle_start;
            default: state_d = LPMS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= LPMS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // led pulse train during accumulation
    always_ff @(posedge clk) begin
        if (sys_rst || state_q != LPMS_PROX_ACCUM) begin
            led_cyc_q <= '0;
            pulses_q <= prox_led_pulse_count;
        end else begin
            led_cyc_q <= pulse_end ? '0 : led_cyc_q + 1'b1;
            if (pulse_end) pulses_q <= pulses_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            led_q <= 1'b0;
        end else begin
            led_q <= (state_d == LPMS_PROX_ACCUM) && !accum_done &&
                ((state_q != LPMS_PROX_ACCUM) ?
                 (prox_led_pulse_count != '0) :
                 (pulse_end || led_cyc_q < LED_W'(LED_ON_LEN - 1)));
        end
    end

    // sticky interrupts: new event wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prox_int_q <= 1'b0;
            amb_int_q <= 1'b0;
        end else begin
            prox_int_q <= prox_fire || (prox_int_q && !int_clear);
            amb_int_q <= amb_fire || (amb_int_q && !int_clear);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !prox_enable) begin
            valid_q <= 1'b0;
        end else if (prox_end) begin
            valid_q <= 1'b1;
        end
    end

    assign led_on = led_q;
    assign prox_int = prox_int_q;
    assign ambient_int = amb_int_q;
    assign prox_result_valid = valid_q;
    assign prox_conv_done = prox_end;
    assign ambient_conv_done = amb_end;
    assign state = state_q;

    // assertions
    // cycles spent in the current state, for the length checks
    logic [31:0] dwell_q;
    // length of the current led on and led off runs
    logic [31:0] led_run_q;
    logic [31:0] led_gap_q;

    always_ff @(posedge clk) begin
        if (sys_rst || state_chg) begin
            dwell_q <= '0;
        end else begin
            dwell_q <= dwell_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !led_q) begin
            led_run_q <= '0;
        end else begin
            led_run_q <= led_run_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || led_q) begin
            led_gap_q <= '0;
        end else begin
            led_gap_q <= led_gap_q + 1'b1;
        end
    end

    sequence prox_done_s;
        state_q == LPMS_PROX_CONV && tmr_done;
    endsequence

    sequence amb_done_s;
        state_q == LPMS_AMB_CONV && tmr_done;
    endsequence

    amb_sleep_a: assert property (@(posedge clk) disable iff (sys_rst)
        amb_done_s ##0 (ambient_int_cause && sleep_after_interrupt)
        |=> state_q == LPMS_SLEEP)
        else $error("no sleep after ambient interrupt");
    amb_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        amb_int_q && !int_clear |=> amb_int_q)
        else $error("ambient interrupt dropped without clear");
    accum_order_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_PROX_ACCUM && state_chg
        |-> state_d == LPMS_PROX_WAIT)
        else $error("accumulation not followed by prox wait");
    amb_order_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_AMB_INIT && state_chg |-> state_d == LPMS_AMB_CONV)
        else $error("ambient init not followed by conversion");
    wait_next_a: assert property (@(posedge clk) disable iff (sys_rst)
        prox_done_s ##0 (wait_enable &&
        !(prox_int_cause && sleep_after_interrupt))
        |=> state_q == LPMS_WAIT)
        else $error("wait state skipped after prox phase");
    init_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_PROX_INIT && state_chg
        |-> dwell_q == 32'(UNIT_LEN - 1))
        else $error("prox init length wrong");
    pwait_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_PROX_WAIT && state_chg
        |-> dwell_q == 32'(UNIT_LEN - 1))
        else $error("prox wait length wrong");
    amb_init_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_AMB_INIT && state_chg
        |-> dwell_q == 32'(UNIT_LEN - 1))
        else $error("ambient init length wrong");
    led_width_a: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(led_q) |-> led_run_q == 32'(LED_ON_LEN))
        else $error("led pulse width wrong");
    led_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(led_q) && $past(state_q) == LPMS_PROX_ACCUM
        |-> led_gap_q == 32'(LED_OFF_LEN))
        else $error("led off gap wrong");

    int_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        prox_int_q && !int_clear |=> prox_int_q)
        else $error("prox interrupt dropped without clear");
    prox_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
        prox_done_s ##0 prox_int_cause |=> prox_int_q)
        else $error("prox interrupt not raised");
    amb_fire_a: assert property (@(posedge clk) disable iff (sys_rst)
        amb_end && ambient_int_cause |=> amb_int_q)
        else $error("ambient interrupt not raised");
    prox_sleep_a: assert property (@(posedge clk) disable iff (sys_rst)
        prox_done_s ##0 (prox_int_cause && sleep_after_interrupt)
        |=> state_q == LPMS_SLEEP)
        else $error("no sleep after prox interrupt");
    sleep_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_SLEEP && pend_int |=> state_q == LPMS_SLEEP)
        else $error("left sleep with interrupt pending");
    prox_order_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q == LPMS_PROX_INIT && state_d != state_q
        |-> state_d == LPMS_PROX_ACCUM)
        else $error("prox init not followed by accumulation");
    valid_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        prox_done_s ##0 prox_enable |=> valid_q)
        else $error("prox valid not set");
    valid_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
        !prox_enable |=> !valid_q)
        else $error("prox valid kept while disabled");
    led_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        state_q != LPMS_PROX_ACCUM && state_d != LPMS_PROX_ACCUM |=> !led_q)
        else $error("led on outside accumulation");
endmodule : lpms_sequencer

// *** include/lpms_pkg.sv ***
// lpms_pkg: constants and state type of the measurement sequencer
// assumes a 50 MHz system clock
package lpms_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_PS = 20000;
    // fixed time unit of the conversion and init states
    localparam int UNIT_TIME_NS = 2730000;
    localparam int UNIT_TIME_US100 = 273;
    localparam int UNIT_CYCLES = (UNIT_TIME_NS * CLK_MHZ) / 1000;
    // led pulse on and off times
    localparam int LED_ON_TIME_NS = 7300;
    localparam int LED_OFF_TIME_NS = 8700;
    localparam int LED_ON_CYCLES =
        (LED_ON_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LED_OFF_CYCLES =
        (LED_OFF_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // long wait multiplier
    localparam int LONG_WAIT_FACTOR = 12;
    // reset value of the time settings: one unit
    localparam logic [7:0] TIME_SETTING_RST = 8'hFF;
    localparam int SETTING_W = 8;

    typedef enum logic [3:0] {
        LPMS_IDLE,
        LPMS_PROX_INIT,
        LPMS_PROX_ACCUM,
        LPMS_PROX_WAIT,
        LPMS_PROX_CONV,
        LPMS_WAIT,
        LPMS_AMB_INIT,
        LPMS_AMB_CONV,
        LPMS_SLEEP
    } lpms_state_t;
endpackage : lpms_pkg

// *** src/lpms_unit_timer.sv ***
// lpms_unit_timer: counts whole time units of a programmable length
// assumes start is a one-cycle pulse; done pulses when the count ends
`timescale 1ns/1ps
module lpms_unit_timer #(
    parameter int UNIT_LEN = 136500,
    parameter int NUM_W = 13
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic [NUM_W-1:0] num_units,
    output logic done
);
    localparam int CNT_W = $clog2(UNIT_LEN + 1);
    logic [CNT_W-1:0] cyc_q;
    logic [NUM_W-1:0] units_q;
    logic run_q;
    wire unit_end = (cyc_q == CNT_W'(UNIT_LEN - 1));
    wire last_unit = (units_q <= NUM_W'(1));

    assign done = run_q && unit_end && last_unit;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_q <= 1'b0;
            cyc_q <= '0;
            units_q <= '0;
        end else if (start) begin
            run_q <= 1'b1;
            cyc_q <= '0;
            units_q <= num_units;
        end else if (run_q) begin
            cyc_q <= unit_end ? '0 : cyc_q + 1'b1;
            if (unit_end) begin
                units_q <= units_q - 1'b1;
                run_q <= !last_unit;
            end
        end
    end
endmodule : lpms_unit_timer

// *** tb/lpms_host_model.sv ***
// lpms_host_model: host that programs the sequencer settings
// assumes sys_rst marks power-on and settings are plain levels
`timescale 1ns/1ps
module lpms_host_model #(
    parameter int BOOT_WAIT = 40
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic prox_enable,
    output logic wait_enable,
    output logic ambient_enable,
    output logic sleep_after_interrupt,
    output logic long_wait_select,
    output logic [7:0] prox_led_pulse_count,
    output logic [7:0] prox_conversion_time,
    output logic [7:0] wait_time_setting,
    output logic [7:0] ambient_integration_time,
    output logic int_clear
);
    int boot_cnt = 0;
    initial begin
        {prox_enable, wait_enable, ambient_enable} = 3'h0;
        {sleep_after_interrupt, long_wait_select, int_clear} = 3'h0;
        prox_led_pulse_count = 8'h00;
        prox_conversion_time = 8'hFF;
        wait_time_setting = 8'hFF;
        ambient_integration_time = 8'hFF;
    end
    // time since power-on
    always @(posedge clk) begin
        if (sys_rst) begin
            boot_cnt <= 0;
        end else if (boot_cnt < BOOT_WAIT) begin
            boot_cnt <= boot_cnt + 1;
        end
    end
    task automatic setup(input logic [4:0] en, input int pc, pt, wt, at);
        @(posedge clk);
        while (boot_cnt < BOOT_WAIT) @(posedge clk);
        #1;
        {prox_enable, wait_enable, ambient_enable} = en[4:2];
        {sleep_after_interrupt, long_wait_select} = en[1:0];
        prox_led_pulse_count = pc[7:0];
        prox_conversion_time = pt[7:0];
        wait_time_setting = wt[7:0];
        ambient_integration_time = at[7:0];
    endtask : setup
    // power-on values, taken while reset holds
    task automatic defaults();
        {prox_enable, wait_enable, ambient_enable} = 3'h0;
        {sleep_after_interrupt, long_wait_select, int_clear} = 3'h0;
        prox_led_pulse_count = 8'h00;
        prox_conversion_time = 8'hFF;
        wait_time_setting = 8'hFF;
        ambient_integration_time = 8'hFF;
    endtask : defaults
    task automatic clear_ints();
        @(posedge clk);
        #1 int_clear = 1'b1;
        @(posedge clk);
        #1 int_clear = 1'b0;
    endtask : clear_ints
endmodule : lpms_host_model

// *** tb/tb_top.sv ***
// tb_top: self-checking bench of the measurement sequencer
// assumes shortened unit and led times, 50 MHz clock
`timescale 1ns/1ps
module tb_top;
    import lpms_pkg::*;
    localparam int UL = 20;
    localparam int ON = 3;
    localparam int OFF = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic prox_enable, wait_enable, ambient_enable, sleep_after_interrupt;
    logic long_wait_select, int_clear, led_on, prox_int, ambient_int;
    logic prox_result_valid, prox_int_cause = 1'b0, ambient_int_cause = 1'b0;
    logic [7:0] prox_led_pulse_count, prox_conversion_time, wait_time_setting;
    logic [7:0] ambient_integration_time;
    lpms_state_t state, prev_st = LPMS_IDLE;
    lpms_state_t exp_st[$];
    int exp_len[$];
    int seg_len = 0, led_cnt = 0, pulses = 0, mismatches = 0, total_checks = 0;
    int seed = 87951;

    lpms_host_model lpms_host_model_i (.clk, .sys_rst, .prox_enable,
        .wait_enable, .ambient_enable, .sleep_after_interrupt,
        .long_wait_select, .prox_led_pulse_count, .prox_conversion_time,
        .wait_time_setting, .ambient_integration_time, .int_clear);
    lpms_sequencer #(.UNIT_LEN(UL), .LED_ON_LEN(ON), .LED_OFF_LEN(OFF))
        lpms_sequencer_i (.clk, .sys_rst, .prox_enable, .wait_enable,
        .ambient_enable, .sleep_after_interrupt, .long_wait_select,
        .prox_led_pulse_count, .prox_conversion_time, .wait_time_setting,
        .ambient_integration_time, .prox_int_cause, .ambient_int_cause,
        .int_clear, .led_on, .prox_int, .ambient_int, .prox_result_valid,
        .prox_conv_done(), .ambient_conv_done(), .state);

    always #10 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // segment monitor: order, length, led time, interrupts
    always @(posedge clk) begin
        #2;
        if (!sys_rst && state !== prev_st) begin
            if (prev_st == LPMS_PROX_WAIT) check(led_cnt, pulses * ON);
            if (prev_st == LPMS_PROX_CONV) check(prox_int, prox_int_cause);
            if (prev_st == LPMS_AMB_CONV) check(ambient_int, ambient_int_cause);
            if (prev_st != LPMS_IDLE && prev_st != LPMS_SLEEP && exp_st.size() > 0) begin
                check(prev_st, exp_st.pop_front());
                check(seg_len, exp_len.pop_front());
            end
            if (prev_st == LPMS_PROX_INIT) led_cnt = 0;
            seg_len = 0;
        end
        seg_len++;
        if (led_on === 1'b1) led_cnt++;
        prev_st = state;
    end

    task automatic push(input lpms_state_t s, input int l);
        exp_st.push_back(s);
        exp_len.push_back(l);
    endtask : push

    // cfg: prox, wait, ambient, sleep, long, prox cause, ambient cause
    task automatic run(input logic [6:0] c, input int pc, pt, wt, at, n,
                       input logic slp);
        int i;
        @(posedge clk);
        #1 sys_rst = 1'b1;
        lpms_host_model_i.defaults();
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        check(state, LPMS_IDLE);
        check({prox_int, ambient_int, led_on, prox_result_valid}, 0);
        pulses = pc;
        {prox_int_cause, ambient_int_cause} = c[1:0];
        repeat (n) begin
            if (c[6]) begin
                push(LPMS_PROX_INIT, UL);
                push(LPMS_PROX_ACCUM, pc == 0 ? 1 : pc * (ON + OFF));
                push(LPMS_PROX_WAIT, UL);
                push(LPMS_PROX_CONV, (256 - pt) * UL);
            end
            if (c[5]) push(LPMS_WAIT, (256 - wt) * UL * (c[2] ? 12 : 1));
            if (c[4]) begin
                push(LPMS_AMB_INIT, UL);
                push(LPMS_AMB_CONV, (256 - at) * UL);
            end
        end
        lpms_host_model_i.setup(c[6:2], pc, pt, wt, at);
        for (i = 0; i < 20000 && exp_st.size() > 0; i++) @(posedge clk);
        check(exp_st.size(), 0);
        if (slp) begin
            #3 check(state, LPMS_SLEEP);
            repeat (8) @(posedge clk);
            #3 check(state, LPMS_SLEEP);
            lpms_host_model_i.clear_ints();
            #2 check({prox_int, ambient_int}, 0);
            for (i = 0; i < 5 && state !== LPMS_PROX_INIT; i++) @(posedge clk);
            #3 check(state, LPMS_PROX_INIT);
        end
    endtask : run

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        run(7'b1000010, 1 + $unsigned($random(seed)) % 4,
            254 + $unsigned($random(seed)) % 2, 255, 255, 2, 1'b0);
        #3 check(prox_result_valid, 1);
        check(prox_int, 1);
        lpms_host_model_i.clear_ints();
        #2 check(prox_int, 0);
        lpms_host_model_i.setup(5'h00, 0, 255, 255, 255);
        repeat (3) @(posedge clk);
        #3 check(prox_result_valid, 0);
        run(7'b1111101, 0, 255, 255, 253, 1, 1'b1);
        run(7'b0110011, 2, 255, 254, 255, 2, 1'b0);
        run(7'b1001010, 1 + $unsigned($random(seed)) % 4, 255, 255, 255, 1,
            1'b1);
        print_verdict();
    end
endmodule : tb_top
